// >>> fswl_host_model.sv
// serial host model that frames instructions towards the status block
`timescale 1ns/10ps
module fswl_host_model (
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  // slow serial clock: the block synchronises every pin
  localparam int HALF = 8;

  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // mode 0, msb first; second byte clocks the answer back
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {b0, b1};
    rd = 8'h00;
    tick(1);
    cs_n_out = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      si_out = sh[15 - i];
      tick(HALF);
      sck_out = 1'b1;
      // an undriven so line must never pass for data
      if (i >= 8) rd = {rd[6:0], (so_oe_in === 1'b1) ? so_in : 1'bx};
      tick(HALF);
      sck_out = 1'b0;
    end
    tick(HALF);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    tick(10);
  endtask
endmodule

// >>> fswl_pkg.sv
// shared constants and types for the flash status and write-latch block
package fswl_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int TMR_W = 24;

  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_FULL_ERASE_A = 8'h60;
  localparam logic [7:0] OP_FULL_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;

  // ----------------------------------------
  // status byte layout and reset values
  // ----------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int PROT_LSB = 2;
  localparam int PROT_MSB = 5;
  localparam int QUAD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] PROT_NONE = 4'h0;

  typedef struct packed {
    logic status_write_lock;
    logic quad_pins_on;
    logic [3:0] protect_level;
    logic write_latch;
    logic busy_flag;
  } fswl_status_t;

  // ----------------------------------------
  // pin bundle, idle levels: sck 0, cs_n 1, si 0, wp_n 1, hold_n 1
  // ----------------------------------------
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic wp_n;
    logic hold_n;
  } fswl_pins_t;

  localparam fswl_pins_t PINS_IDLE = 5'h0b;

  typedef enum logic [1:0] {BUSY_NONE, BUSY_ARRAY, BUSY_STATUS} fswl_busy_t;

endpackage

// >>> fswl_spi_shift.sv
// serial pin synchroniser and byte shifter for the status block
`timescale 1ns/10ps
module fswl_spi_shift
  import fswl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire fswl_pins_t pins_in,
  input wire logic [7:0] tx_byte_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic rx_first_out,
  output logic frame_end_out,
  output logic so_out,
  output fswl_pins_t pins_sync_out
);

  fswl_pins_t sync1_reg;
  fswl_pins_t sync2_reg;
  fswl_pins_t sync3_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic first_reg;
  logic [7:0] tx_sh_reg;
  logic sck_rise;
  logic sck_fall;

  // ----------------------------------------
  // synchronisers; sync3 only serves edge detection
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= PINS_IDLE;
      sync2_reg <= PINS_IDLE;
      sync3_reg <= PINS_IDLE;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign pins_sync_out = sync2_reg;
  assign sck_rise = sync2_reg.sck & ~sync3_reg.sck & ~sync2_reg.cs_n;
  assign sck_fall = ~sync2_reg.sck & sync3_reg.sck & ~sync2_reg.cs_n;

  // ----------------------------------------
  // receive: sample on rising sck, msb first
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      first_reg <= 1'b1;
      rx_byte_out <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_first_out <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      frame_end_out <= sync2_reg.cs_n & ~sync3_reg.cs_n;
      if (sync2_reg.cs_n) begin
        bit_cnt_reg <= 3'h0;
        first_reg <= 1'b1;
      end else if (sck_rise) begin
        rx_sh_reg <= {rx_sh_reg[5:0], sync2_reg.si};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          rx_byte_out <= {rx_sh_reg, sync2_reg.si};
          rx_valid_out <= 1'b1;
          rx_first_out <= first_reg;
          first_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // transmit: reload at each byte boundary so the byte repeats
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_sh_reg <= 8'h00;
    end else if (sync2_reg.cs_n) begin
      tx_sh_reg <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt_reg == 3'h0) begin
        tx_sh_reg <= tx_byte_in; // [RQ20]
      end else begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
    end
  end

  assign so_out = tx_sh_reg[7];

endmodule

// >>> fswl_status_latch.sv
// status byte, write-enable latch and busy gating of a serial flash
`timescale 1ns/10ps
//
// Contract
// RQ1: busy reads in status bit 0
// RQ2: write latch held in status bit 1
// RQ3: four protect bits in status bits 2-5
// RQ4: quad pin enable in status bit 6
// RQ5: status write lock in status bit 7
// RQ6: status write leaves write latch untouched
// RQ7: status write updates bits 7 to 2
// RQ8: busy read-only, set during whole operation
// RQ9: while busy discard all but reads, resets
// RQ10: suspend accepted during array busy
// RQ11: completion clears busy, new instructions accepted
// RQ12: latch zero inhibits gated writes
// RQ13: unlock instruction sets write latch
// RQ14: host unlocks before program, erase, writes
// RQ15: lock instruction clears write latch
// RQ16: completed write operation clears latch
// RQ17: locked with wp low ignores status write
// RQ18: full erase only with protect bits zero
// RQ19: quad enable turns wp, hold into data
// RQ20: status read repeats byte msb first
module fswl_status_latch
  import fswl_pkg::*;
#(
  parameter int unsigned STATUS_WRITE_NS = 2000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic hold_n_in,
  input wire logic array_done_in,
  output logic so_out,
  output logic so_oe_out,
  output logic quad_pins_out,
  output logic [7:0] status_out,
  output logic array_start_out,
  output logic [7:0] array_cmd_out,
  output logic suspend_out,
  output logic abort_out
);

  localparam int SW_CYCLES = (STATUS_WRITE_NS + CLK_NS - 1) / CLK_NS;

  fswl_pins_t pins_raw;
  fswl_pins_t pins_sync;
  fswl_status_t status_now;
  fswl_busy_t busy_reg;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_first;
  logic frame_end;
  logic so_bit;
  logic [7:0] opcode_reg;
  logic [7:0] data_reg;
  logic cmd_valid_reg;
  logic have_data_reg;
  logic write_latch_reg;
  logic [5:0] nv_bits_reg;
  logic [TMR_W-1:0] timer_reg;
  logic reset_arm_reg;
  logic exec_now;
  logic busy_now;
  logic busy_done;
  logic hw_reset;
  logic soft_reset;
  logic sr_protected;
  logic is_array_op;
  logic is_full_erase;
  logic accept_now;
  logic array_go;

  // ----------------------------------------
  // serial front end
  // ----------------------------------------
  assign pins_raw = '{sck: sck_in, cs_n: cs_n_in, si: si_in, wp_n: wp_n_in, hold_n: hold_n_in};

  fswl_spi_shift u_shift (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in(pins_raw),
    .tx_byte_in(status_now),
    .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid),
    .rx_first_out(rx_first),
    .frame_end_out(frame_end),
    .so_out(so_bit),
    .pins_sync_out(pins_sync)
  );

  // ----------------------------------------
  // status byte assembly
  // ----------------------------------------
  assign busy_now = (busy_reg != BUSY_NONE);
  assign status_now.busy_flag = busy_now; // [RQ1] [RQ8]
  assign status_now.write_latch = write_latch_reg; // [RQ2]
  assign status_now.protect_level = nv_bits_reg[3:0]; // [RQ3]
  assign status_now.quad_pins_on = nv_bits_reg[4]; // [RQ4]
  assign status_now.status_write_lock = nv_bits_reg[5]; // [RQ5]

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // wp and hold lose their control role once quad pins are on
  assign sr_protected = status_now.status_write_lock & ~status_now.quad_pins_on
    & ~pins_sync.wp_n; // [RQ17] [RQ19]
  assign hw_reset = ~status_now.quad_pins_on & ~pins_sync.hold_n; // [RQ19]
  assign exec_now = frame_end & cmd_valid_reg;
  assign soft_reset = exec_now & reset_arm_reg & (opcode_reg == OP_RESET_GO);
  assign is_full_erase = (opcode_reg == OP_FULL_ERASE_A) || (opcode_reg == OP_FULL_ERASE_B);
  assign is_array_op = is_full_erase || (opcode_reg == OP_PAGE_PROG)
    || (opcode_reg == OP_SECTOR_ERASE) || (opcode_reg == OP_BLOCK_ERASE);
  // busy lets only reads, resets and suspend through
  assign accept_now = exec_now & ~busy_now & ~hw_reset; // [RQ9]
  assign busy_done = ((busy_reg == BUSY_ARRAY) & array_done_in)
    | ((busy_reg == BUSY_STATUS) & (timer_reg == TMR_W'(1)));
  // an ignored array instruction must leave no trace on the engine outputs
  assign array_go = accept_now & write_latch_reg & is_array_op
    & (~is_full_erase | (nv_bits_reg[3:0] == PROT_NONE)); // [RQ12] [RQ18]

  // ----------------------------------------
  // frame capture
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      opcode_reg <= 8'h00;
      data_reg <= 8'h00;
      cmd_valid_reg <= 1'b0;
      have_data_reg <= 1'b0;
    end else if (frame_end) begin
      cmd_valid_reg <= 1'b0;
      have_data_reg <= 1'b0;
    end else if (rx_valid && rx_first) begin
      opcode_reg <= rx_byte;
      cmd_valid_reg <= 1'b1;
    end else if (rx_valid && !have_data_reg) begin
      data_reg <= rx_byte;
      have_data_reg <= 1'b1;
    end
  end

  // status read drives so for the rest of the frame, even while busy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      so_oe_out <= 1'b0;
    end else if (frame_end) begin
      so_oe_out <= 1'b0;
    end else if (rx_valid && rx_first && rx_byte == OP_STATUS_READ) begin
      so_oe_out <= 1'b1; // [RQ20]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_arm_reg <= 1'b0;
    end else if (exec_now) begin
      reset_arm_reg <= (opcode_reg == OP_RESET_ARM);
    end
  end

  // ----------------------------------------
  // write-enable latch
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      write_latch_reg <= 1'b0;
    end else if (hw_reset || soft_reset || busy_done) begin
      write_latch_reg <= 1'b0; // [RQ16]
    end else if (accept_now && opcode_reg == OP_WRITE_UNLOCK) begin
      write_latch_reg <= 1'b1; // [RQ13]
    end else if (accept_now && opcode_reg == OP_WRITE_LOCK) begin
      write_latch_reg <= 1'b0; // [RQ15]
    end
  end

  // ----------------------------------------
  // non-volatile status bits; the latch is not written here
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_bits_reg <= STATUS_RESET[LOCK_BIT:PROT_LSB];
    end else if (accept_now && opcode_reg == OP_STATUS_WRITE && have_data_reg
                 && write_latch_reg && !sr_protected) begin
      nv_bits_reg <= data_reg[LOCK_BIT:PROT_LSB]; // [RQ6] [RQ7] [RQ12] [RQ17]
    end
  end

  // ----------------------------------------
  // busy tracking
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg <= BUSY_NONE;
      timer_reg <= '0;
    end else if (hw_reset || soft_reset || busy_done) begin
      busy_reg <= BUSY_NONE; // [RQ11]
      timer_reg <= '0;
    end else if (accept_now && write_latch_reg) begin
      if (opcode_reg == OP_STATUS_WRITE && have_data_reg && !sr_protected) begin
        busy_reg <= BUSY_STATUS; // [RQ8]
        timer_reg <= TMR_W'(SW_CYCLES);
      end else if (is_array_op && (!is_full_erase || nv_bits_reg[3:0] == PROT_NONE)) begin
        busy_reg <= BUSY_ARRAY; // [RQ8] [RQ18]
      end
    end else if (busy_reg == BUSY_STATUS) begin
      timer_reg <= timer_reg - TMR_W'(1);
    end
  end

  // ----------------------------------------
  // registered outputs: array engine, quad pins, status byte and so
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      array_start_out <= 1'b0;
      array_cmd_out <= 8'h00;
      suspend_out <= 1'b0;
      abort_out <= 1'b0;
      quad_pins_out <= 1'b0;
      status_out <= STATUS_RESET;
      so_out <= 1'b0;
    end else begin
      array_start_out <= array_go; // [RQ12] [RQ18]
      if (array_go) begin
        array_cmd_out <= opcode_reg;
      end
      suspend_out <= exec_now & (busy_reg == BUSY_ARRAY) & ~array_done_in
        & (opcode_reg == OP_SUSPEND); // [RQ10]
      abort_out <= hw_reset | soft_reset;
      quad_pins_out <= status_now.quad_pins_on; // [RQ19]
      status_out <= status_now;
      so_out <= so_bit;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_busy_bit_pos: assert property (status_out[BUSY_BIT] == $past(busy_reg != BUSY_NONE)) // [RQ1]
    else $error("busy bit does not follow busy state");
  a_status_write_cmd_keeps_latch: assert property (exec_now && opcode_reg == OP_STATUS_WRITE && !hw_reset // [RQ6]
    && !soft_reset && !busy_done |=> write_latch_reg == $past(write_latch_reg))
    else $error("status write changed the write latch");
  a_unlock_sets: assert property (accept_now && opcode_reg == OP_WRITE_UNLOCK // [RQ13]
    |=> write_latch_reg ##1 status_out[LATCH_BIT])
    else $error("unlock did not set the write latch");
  a_lock_clears: assert property (accept_now && opcode_reg == OP_WRITE_LOCK // [RQ15]
    |=> !write_latch_reg)
    else $error("lock did not clear the write latch");
  a_done_clears_all: assert property (busy_done |=> !write_latch_reg && busy_reg == BUSY_NONE) // [RQ16]
    else $error("completion left busy or latch set");
  a_busy_discards: assert property (exec_now && busy_now && is_array_op // [RQ9]
    |=> !array_start_out)
    else $error("array instruction taken while busy");
  a_start_needs_latch: assert property (array_start_out |-> $past(write_latch_reg)) // [RQ12]
    else $error("array start without write latch");
  a_erase_unprotected: assert property (array_start_out && (array_cmd_out == OP_FULL_ERASE_A // [RQ18]
    || array_cmd_out == OP_FULL_ERASE_B) |-> $past(nv_bits_reg[3:0]) == PROT_NONE)
    else $error("full erase started with protect bits set");
  a_locked_ignores: assert property (exec_now && opcode_reg == OP_STATUS_WRITE && sr_protected // [RQ17]
    |=> $stable(nv_bits_reg))
    else $error("protected status write changed bits");
  a_suspend_busy: assert property (suspend_out |-> $past(busy_reg) == BUSY_ARRAY) // [RQ10]
    else $error("suspend issued while not in array operation");
  a_status_busy_holds: assert property ($rose(busy_reg == BUSY_STATUS) && SW_CYCLES > 8 // [RQ8]
    |-> (busy_reg == BUSY_STATUS || hw_reset || soft_reset)[*4])
    else $error("status write busy ended too early");
  a_read_drives: assert property (rx_valid && rx_first && rx_byte == OP_STATUS_READ // [RQ20]
    |=> so_oe_out)
    else $error("status read did not enable output");

  c_unlock_then_prog: cover property (accept_now && opcode_reg == OP_WRITE_UNLOCK
    ##[1:1000] array_start_out);
  c_status_write_done: cover property ((busy_reg == BUSY_STATUS) ##1 busy_done);
  c_suspend: cover property (suspend_out);
  c_poll_while_busy: cover property (so_oe_out && busy_now);

endmodule

// >>> testbench.sv
// self-checking bench for the status byte and write-latch block
`timescale 1ns/10ps
module testbench;
  import fswl_pkg::*;
  localparam int unsigned SW_NS = 50000;
  localparam logic [39:0] OPS = {OP_PAGE_PROG, OP_SECTOR_ERASE, OP_BLOCK_ERASE,
                                 OP_FULL_ERASE_A, OP_FULL_ERASE_B};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sck, cs_n, si, so, so_oe, quad_pins, arr_start, susp, abrt;
  logic wp_n = 1'b1;
  logic hold_n = 1'b1;
  logic arr_done = 1'b0;
  logic [7:0] status, arr_cmd, rd, last_cmd;
  logic [31:0] lfsr = 32'h7b06_aaa9;
  int err_count = 0;
  int checked = 0;
  int n_start = 0;
  int n_susp = 0;
  int n_abort = 0;
  // reference state: nv bits 7:2, latch, busy, array busy, previous opcode
  logic [5:0] m_nv = 6'h00;
  logic m_wel = 1'b0;
  logic m_busy = 1'b0;
  logic m_arr = 1'b0;
  logic [7:0] m_prev = 8'h00;

  always #(CLK_NS / 2) clk_in = ~clk_in;

  fswl_status_latch #(.STATUS_WRITE_NS(SW_NS)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .wp_n_in(wp_n), .hold_n_in(hold_n),
    .array_done_in(arr_done), .so_out(so), .so_oe_out(so_oe), .quad_pins_out(quad_pins),
    .status_out(status), .array_start_out(arr_start), .array_cmd_out(arr_cmd),
    .suspend_out(susp), .abort_out(abrt));

  fswl_host_model u_host (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .sck_out(sck),
    .cs_n_out(cs_n), .si_out(si));

  // pulses are counted once per cycle high; abort stays high while hold_n is low with quad pins off
  always @(posedge clk_in) begin
    if (arr_start === 1'b1) begin
      n_start <= n_start + 1;
      last_cmd <= arr_cmd;
    end
    if (susp === 1'b1) n_susp <= n_susp + 1;
    if (abrt === 1'b1) n_abort <= n_abort + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [7:0] m_status();
    return {m_nv, m_wel, m_busy};
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int n);
    int s0, u0, a0;
    logic take;
    logic [7:0] exp;
    s0 = n_start;
    u0 = n_susp;
    a0 = n_abort;
    exp = m_status();
    u_host.frame(op, dat, n, rd);
    take = !m_busy || op == OP_STATUS_READ || op == OP_RESET_ARM || op == OP_RESET_GO
      || (op == OP_SUSPEND && m_arr);
    if (take) begin
      case (op)
        OP_WRITE_UNLOCK: m_wel = 1'b1;
        OP_WRITE_LOCK: m_wel = 1'b0;
        OP_SUSPEND: if (m_arr) u0++;
        OP_STATUS_WRITE: begin
          if (m_wel && n > 1 && !(m_nv[5] && !m_nv[4] && !wp_n)) begin
            m_nv = dat[7:2];
            m_busy = 1'b1;
          end
        end
        OP_RESET_GO: begin
          if (m_prev == OP_RESET_ARM) begin
            {m_busy, m_wel, m_arr} = 3'b000;
            a0++;
          end
        end
        OP_PAGE_PROG, OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_FULL_ERASE_A, OP_FULL_ERASE_B: begin
          if (m_wel && (op != OP_FULL_ERASE_A && op != OP_FULL_ERASE_B || m_nv[3:0] == PROT_NONE)) begin
            {m_busy, m_arr} = 2'b11;
            s0++;
          end
        end
        default: ;
      endcase
    end
    m_prev = op;
    if (op == OP_STATUS_READ) check(rd, exp);
    check(status, m_status());
    check(8'(n_start), 8'(s0));
    check(8'(n_susp), 8'(u0));
    check(8'(n_abort), 8'(a0));
  endtask

  task automatic wait_idle();
    int c;
    c = 0;
    while (status[0] !== 1'b0 && c < 2000) begin
      @(negedge clk_in);
      c++;
    end
    {m_busy, m_wel} = 2'b00;
    check(8'(c > 0 && c < 1010), 8'h01);
    check(status, m_status());
    check({7'h00, quad_pins}, {7'h00, m_nv[4]});
  endtask

  task automatic end_array();
    @(negedge clk_in);
    arr_done = 1'b1;
    @(negedge clk_in);
    arr_done = 1'b0;
    repeat (4) @(negedge clk_in);
    {m_busy, m_wel, m_arr} = 3'b000;
    check(status, m_status());
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check(status, STATUS_RESET);
    cmd(OP_STATUS_READ, 8'h00, 2);
    cmd(OP_STATUS_WRITE, 8'hfc, 2);
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      cmd(OP_WRITE_UNLOCK, 8'h00, 1);
      cmd(OP_STATUS_WRITE, lfsr[7:0] & 8'h7c, 2);
      cmd(OP_STATUS_READ, 8'h00, 2);
      cmd(OP_WRITE_LOCK, 8'h00, 1);
      wait_idle();
    end
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_WRITE_LOCK, 8'h00, 1);
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_STATUS_WRITE, 8'h80, 2);
    wait_idle();
    wp_n = 1'b0;
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_STATUS_WRITE, 8'h3c, 2);
    wp_n = 1'b1;
    cmd(OP_STATUS_WRITE, 8'h04, 2);
    wait_idle();
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_FULL_ERASE_B, 8'h00, 1);
    cmd(OP_STATUS_WRITE, 8'h00, 2);
    wait_idle();
    for (int k = 0; k < 5; k++) begin
      cmd(OP_WRITE_UNLOCK, 8'h00, 1);
      cmd(OPS[8*k +: 8], 8'h00, 1);
      check(last_cmd, OPS[8*k +: 8]);
      cmd(OP_SUSPEND, 8'h00, 1);
      cmd(OP_WRITE_LOCK, 8'h00, 1);
      end_array();
    end
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_PAGE_PROG, 8'h00, 1);
    cmd(OP_RESET_ARM, 8'h00, 1);
    cmd(OP_RESET_GO, 8'h00, 1);
    cmd(OP_SECTOR_ERASE, 8'h00, 1);
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    cmd(OP_STATUS_WRITE, 8'h40, 2);
    wait_idle();
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    hold_n = 1'b0;
    repeat (8) @(negedge clk_in);
    hold_n = 1'b1;
    repeat (8) @(negedge clk_in);
    check(status, m_status());
    check(8'(n_abort), 8'h01);
    cmd(OP_STATUS_WRITE, 8'h00, 2);
    wait_idle();
    cmd(OP_WRITE_UNLOCK, 8'h00, 1);
    hold_n = 1'b0;
    repeat (8) @(negedge clk_in);
    hold_n = 1'b1;
    repeat (8) @(negedge clk_in);
    m_wel = 1'b0;
    check(status, m_status());
    check(8'(n_abort > 0), 8'h01);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check(status, STATUS_RESET);
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end
endmodule
